// ---- clk_ctrl.sv ----
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Oscillator ticks and requests
    input  wire logic [1:0]  osc_tick,
    input  wire logic [1:0]  osc_analog_ready,
    input  wire logic [1:0]  osc_periph_req,
    input  wire logic        external_clock_input,
    // Fuses
    input  wire logic        fuse_frequency_choice,
    input  wire logic        fuse_trim_freeze,
    // Clock outputs
    output logic             peripheral_clock_signal,
    output logic [1:0]       osc_power,
    output logic [1:0]       osc_gate,
    output logic [5:0]       fast_osc_freq_trim,
    output logic [3:0]       fast_osc_temp_slope_trim,
    // Interrupt
    output logic             irq
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [1:0] sel_q, cur_q;
    logic [7:0] presc_q;
    logic       freeze_q, pending_q, trim_lock_q;
    logic [1:0] keep_q;
    logic [5:0] ftrim_q;
    logic [3:0] ttrim_q;
    logic [2:0] prot_q;
    logic [3:0] ev_q, mask_q;
    logic [1:0] stable_q, power_q, gate_q;
    logic [2:0] gate_cnt_q [2];
    logic [1:0] ext_cnt_q;
    logic       ext_started_q;
    logic [5:0] div_cnt_q;
    logic       ptick_q, irq_q;
    logic [1:0] stable_d;
    logic       ext_d;

    wr_state_e  wst_q;
    logic       aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [7:0] aw_idx_q, wdata_q;
    logic       wlane_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    function automatic logic [6:0] ratio(input logic [3:0] code);
        case (code)
            4'h0: ratio = 7'd2;
            4'h1: ratio = 7'd4;
            4'h2: ratio = 7'd8;
            4'h3: ratio = 7'd16;
            4'h4: ratio = 7'd32;
            4'h5: ratio = 7'd64;
            4'h8: ratio = 7'd6;
            4'h9: ratio = 7'd10;
            4'ha: ratio = 7'd12;
            4'hb: ratio = 7'd24;
            4'hc: ratio = 7'd48;
            default: ratio = 7'd0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        case (idx)
            IDX_SELECT, IDX_PRESCALE, IDX_FREEZE, IDX_STATE,
            IDX_FAST_CTRL, IDX_FAST_TRIMA, IDX_FAST_TRIMB,
            IDX_SLOW_CTRL, IDX_KEY, IDX_IRQ_STAT, IDX_IRQ_MASK:
                mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic wr_fire, prot_ok, trim_free, rd_fire;
    logic [7:0] ar_idx;
    assign wr_fire   = (wst_q == WR_IDLE) && aw_have_q && w_have_q;
    assign prot_ok   = (prot_q != 3'h0) && wlane_q;
    assign trim_free = !trim_lock_q && !(freeze_q && cur_q == SRC_FAST);
    assign ar_idx    = s_axi_araddr[9:2];
    assign rd_fire   = s_axi_arvalid && !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_idx_q  <= 8'h00;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
            wst_q     <= WR_IDLE;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wlane_q  <= s_axi_wstrb[0];
            end
            case (wst_q)
                WR_IDLE: if (wr_fire) begin
                    wst_q     <= WR_RESP;
                    bvalid_q  <= 1'b1;
                    bresp_q   <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
                end
                WR_RESP: if (s_axi_bready) begin
                    wst_q     <= WR_IDLE;
                    bvalid_q  <= 1'b0;
                    aw_have_q <= 1'b0;
                    w_have_q  <= 1'b0;
                end
                default: wst_q <= WR_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Protection window and control registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_q <= 3'h0;
        end else if (wr_fire && wlane_q && aw_idx_q == IDX_KEY) begin
            prot_q <= (wdata_q == KEY_VALUE) ? KEY_WINDOW : 3'h0;
        end else if (wr_fire && prot_q != 3'h0) begin
            prot_q <= prot_q - 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q    <= SRC_FAST;
            presc_q  <= PRESC_RESET;
            freeze_q <= 1'b0;
            keep_q   <= 2'b00;
            mask_q   <= 4'h0;
        end else if (wr_fire && wlane_q) begin
            case (aw_idx_q)
                IDX_SELECT:
                    if (prot_ok && !freeze_q && wdata_q[1:0] != SRC_RSVD)
                        sel_q <= wdata_q[1:0];
                IDX_PRESCALE:
                    if (prot_ok && !freeze_q &&
                        ratio(wdata_q[4:PRESC_DIV_LSB]) != 7'd0)
                        presc_q <= {3'h0, wdata_q[4:0]};
                IDX_FREEZE:
                    if (prot_ok && !freeze_q)
                        freeze_q <= wdata_q[0];
                IDX_FAST_CTRL:
                    if (prot_ok) keep_q[0] <= wdata_q[KEEP_ON_BIT];
                IDX_SLOW_CTRL:
                    if (prot_ok) keep_q[1] <= wdata_q[KEEP_ON_BIT];
                IDX_IRQ_MASK:
                    mask_q <= wdata_q[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_lock_q <= fuse_trim_freeze;
            ftrim_q <= fuse_frequency_choice ? FREQ_TRIM_1
                                             : FREQ_TRIM_0;
            ttrim_q <= fuse_frequency_choice ? TEMP_TRIM_1
                                             : TEMP_TRIM_0;
        end else if (wr_fire && prot_ok && trim_free) begin
            if (aw_idx_q == IDX_FAST_TRIMA)
                ftrim_q <= wdata_q[5:0];
            if (aw_idx_q == IDX_FAST_TRIMB)
                ttrim_q <= wdata_q[3:0];
        end
    end

    // ------------------------------------------------------------
    // Internal oscillators
    // ------------------------------------------------------------
    logic [1:0] req;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_osc
            localparam logic [1:0] SRC = 2'(gi);
            assign req[gi] = sel_q == SRC || cur_q == SRC ||
                             osc_periph_req[gi];
            assign stable_d[gi] = req[gi] && gate_cnt_q[gi] == GATE_CYCLES;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    gate_cnt_q[gi] <= 3'h0;
                    stable_q[gi]   <= 1'b0;
                    power_q[gi]    <= 1'b0;
                    gate_q[gi]     <= 1'b0;
                end else begin
                    power_q[gi] <= req[gi] || keep_q[gi];
                    if (!req[gi])
                        gate_cnt_q[gi] <= 3'h0;
                    else if (osc_tick[gi] && gate_cnt_q[gi] != GATE_CYCLES &&
                             (keep_q[gi] || osc_analog_ready[gi]))
                        gate_cnt_q[gi] <= gate_cnt_q[gi] + 3'h1;
                    stable_q[gi] <= stable_d[gi];
                    gate_q[gi]   <= stable_d[gi];
                end
            end
            a_keep_powers: assert property (@(posedge aclk)
                disable iff (!aresetn) keep_q[gi] |=> power_q[gi])
                else $error("kept-on oscillator not powered");
            a_gate_needs_req: assert property (@(posedge aclk)
                disable iff (!aresetn) !req[gi] |=> !gate_q[gi])
                else $error("gate open without request");
            a_stable_four: assert property (@(posedge aclk)
                disable iff (!aresetn) $rose(stable_q[gi])
                |-> $past(gate_cnt_q[gi]) == GATE_CYCLES)
                else $error("gate opened before four cycles");
            a_stable_req: assert property (@(posedge aclk)
                disable iff (!aresetn) stable_q[gi] |-> $past(req[gi]))
                else $error("stable flag without request");
        end
    endgenerate

    // ------------------------------------------------------------
    // External clock and source switch
    // ------------------------------------------------------------
    logic ext_req, new_ok;
    assign ext_req = sel_q == SRC_EXT || cur_q == SRC_EXT;
    assign ext_d   = ext_req && ext_cnt_q == EXT_CYCLES;
    always_comb begin
        case (sel_q)
            SRC_FAST: new_ok = stable_q[0];
            SRC_SLOW: new_ok = stable_q[1];
            SRC_EXT:  new_ok = ext_started_q;
            default:  new_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_cnt_q     <= 2'h0;
            ext_started_q <= 1'b0;
            cur_q         <= SRC_FAST;
            pending_q     <= 1'b0;
        end else begin
            if (!ext_req)
                ext_cnt_q <= 2'h0;
            else if (external_clock_input && ext_cnt_q != EXT_CYCLES)
                ext_cnt_q <= ext_cnt_q + 2'h1;
            ext_started_q <= ext_d;
            if (sel_q != cur_q && new_ok) begin
                cur_q     <= sel_q;
                pending_q <= 1'b0;
            end else begin
                pending_q <= sel_q != cur_q;
            end
        end
    end

    a_switch_ends: assert property (@(posedge aclk)
        disable iff (!aresetn)
        sel_q != cur_q && new_ok |=> !pending_q && cur_q == $past(sel_q))
        else $error("switch did not complete");
    a_ext_start: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ext_started_q |-> $past(ext_req))
        else $error("external started without request");

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic       main_tick, div_end;
    logic [6:0] div_n;
    always_comb begin
        case (cur_q)
            SRC_FAST: main_tick = gate_q[0];
            SRC_SLOW: main_tick = gate_q[1];
            SRC_EXT:  main_tick = external_clock_input;
            default:  main_tick = 1'b0;
        endcase
        main_tick = main_tick && (cur_q == SRC_EXT || osc_tick[cur_q[0]]);
    end
    assign div_n   = ratio(presc_q[4:PRESC_DIV_LSB]);
    assign div_end = {1'b0, div_cnt_q} >= div_n - 7'd1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 6'h00;
            ptick_q   <= 1'b0;
        end else begin
            ptick_q <= main_tick &&
                       (!presc_q[PRESC_ON_BIT] || div_end);
            if (main_tick)
                div_cnt_q <= div_end ? 6'h00 : div_cnt_q + 6'h01;
        end
    end

    a_undivided: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !presc_q[PRESC_ON_BIT] && main_tick |=> ptick_q)
        else $error("prescaler off but tick lost");
    a_divided_gap: assert property (@(posedge aclk)
        disable iff (!aresetn)
        presc_q[PRESC_ON_BIT] && main_tick && !div_end |=> !ptick_q)
        else $error("divided tick too early");

    // ------------------------------------------------------------
    // Interrupt status, read channel
    // ------------------------------------------------------------
    logic [3:0] ev_set;
    logic       ev_clr;
    assign ev_set = {ext_d & ~ext_started_q, stable_d[1] & ~stable_q[1],
                     stable_d[0] & ~stable_q[0],
                     (sel_q != cur_q) & new_ok};
    assign ev_clr = rd_fire && ar_idx == IDX_IRQ_STAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_q  <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            ev_q  <= (ev_clr ? 4'h0 : ev_q) | ev_set;
            irq_q <= |(((ev_clr ? 4'h0 : ev_q) | ev_set) & mask_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
            case (ar_idx)
                IDX_SELECT:     rdata_q <= {30'h0, sel_q};
                IDX_PRESCALE:   rdata_q <= {24'h0, presc_q};
                IDX_FREEZE:     rdata_q <= {31'h0, freeze_q};
                IDX_STATE:      rdata_q <= {24'h0, ext_started_q, 1'b0,
                                            stable_q[1], stable_q[0], 3'h0,
                                            pending_q};
                IDX_FAST_CTRL:  rdata_q <= {30'h0, keep_q[0], 1'b0};
                IDX_FAST_TRIMA: rdata_q <= {26'h0, ftrim_q};
                IDX_FAST_TRIMB: rdata_q <= {24'h0, trim_lock_q, 3'h0, ttrim_q};
                IDX_SLOW_CTRL:  rdata_q <= {30'h0, keep_q[1], 1'b0};
                IDX_IRQ_STAT:   rdata_q <= {28'h0, ev_q};
                IDX_IRQ_MASK:   rdata_q <= {28'h0, mask_q};
                default:        rdata_q <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    a_freeze_holds: assert property (@(posedge aclk)
        disable iff (!aresetn)
        freeze_q |=> freeze_q)
        else $error("freeze released without reset");
    a_frozen_presc: assert property (@(posedge aclk)
        disable iff (!aresetn)
        freeze_q && wr_fire |=> $stable(presc_q) && $stable(sel_q))
        else $error("frozen register changed");
    a_fuse_trim: assert property (@(posedge aclk)
        disable iff (!aresetn)
        trim_lock_q |=> $stable(ftrim_q) && $stable(ttrim_q))
        else $error("fuse-locked trim changed");
    a_no_key: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire && prot_q == 3'h0 |=> $stable(presc_q)
        && $stable(keep_q) && $stable(freeze_q))
        else $error("unprotected write took effect");

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign peripheral_clock_signal  = ptick_q;
    assign osc_power                = power_q;
    assign osc_gate                 = gate_q;
    assign fast_osc_freq_trim       = ftrim_q;
    assign fast_osc_temp_slope_trim = ttrim_q;
    assign irq                      = irq_q;
endmodule

// ---- clk_ctrl_pkg.sv ----
package clk_ctrl_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SELECT     = 8'h00;
    localparam logic [7:0] IDX_PRESCALE   = 8'h01;
    localparam logic [7:0] IDX_FREEZE     = 8'h02;
    localparam logic [7:0] IDX_STATE      = 8'h03;
    localparam logic [7:0] IDX_FAST_CTRL  = 8'h10;
    localparam logic [7:0] IDX_FAST_TRIMA = 8'h11;
    localparam logic [7:0] IDX_FAST_TRIMB = 8'h12;
    localparam logic [7:0] IDX_SLOW_CTRL  = 8'h18;
    localparam logic [7:0] IDX_KEY        = 8'h20;
    localparam logic [7:0] IDX_IRQ_STAT   = 8'h21;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h22;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PRESC_ON_BIT   = 0;
    localparam int PRESC_DIV_LSB  = 1;
    localparam int KEEP_ON_BIT    = 1;
    localparam int TRIM_LOCK_BIT  = 7;
    localparam int ST_EXT_BIT     = 7;
    localparam int ST_SLOW_BIT    = 5;
    localparam int ST_FAST_BIT    = 4;
    localparam int ST_SWITCH_BIT  = 0;
    // ------------------------------------------------------------
    // Reset values, codes and counts
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_FAST     = 2'h0;
    localparam logic [1:0] SRC_SLOW     = 2'h1;
    localparam logic [1:0] SRC_RSVD     = 2'h2;
    localparam logic [1:0] SRC_EXT      = 2'h3;
    localparam logic [7:0] PRESC_RESET  = 8'h11;
    localparam logic [7:0] KEY_VALUE    = 8'h5a; // Arbitrary value
    localparam logic [2:0] KEY_WINDOW   = 3'h4;
    localparam logic [2:0] GATE_CYCLES  = 3'h4;
    localparam logic [1:0] EXT_CYCLES   = 2'h2;
    localparam logic [5:0] FREQ_TRIM_0  = 6'h20;
    localparam logic [5:0] FREQ_TRIM_1  = 6'h1f;
    localparam logic [3:0] TEMP_TRIM_0  = 4'h8;
    localparam logic [3:0] TEMP_TRIM_1  = 4'h7;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    // Interrupt status bits
    localparam int EV_SWITCH = 0;
    localparam int EV_FAST   = 1;
    localparam int EV_SLOW   = 2;
    localparam int EV_EXT    = 3;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_e;
endpackage

// ---- tb_main_clock_prescale_lock_status.sv ----
`timescale 1ns/1ps
module tb_main_clock_prescale_lock_status
    import clk_ctrl_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, ext, fsel;
    logic        flock, pclk, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb, ttrim;
    logic [1:0]  bresp, rresp, tick, ardy, preq, pwr, gate, rs;
    logic [5:0]  ftrim;
    int          miscompares, comparisons, cycles, c;
    logic [3:0]  code_tab [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                   4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hc};
    int          ratio_tab [12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 1};

    clk_ctrl u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .osc_tick(tick), .osc_analog_ready(ardy),
        .osc_periph_req(preq), .external_clock_input(ext),
        .fuse_frequency_choice(fsel), .fuse_trim_freeze(flock),
        .peripheral_clock_signal(pclk), .osc_power(pwr), .osc_gate(gate),
        .fast_osc_freq_trim(ftrim), .fast_osc_temp_slope_trim(ttrim),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        comparisons++;
        if (got < exp - 1 || got > exp + 1) begin
            miscompares++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bit ap, wp;
        int n;
        ap = 1;
        wp = 1;
        n = 0;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (!ap && !wp && bvalid === 1'b1) begin
                rs = bresp;
                break;
            end
            if (ap && awready === 1'b1) begin
                ap = 0;
                awvalid <= 1'b0;
            end
            if (wp && wready === 1'b1) begin
                wp = 0;
                wvalid <= 1'b0;
            end
            if (n > 50) begin
                chk(1, 0);
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] idx);
        bit ap;
        int n;
        ap = 1;
        n = 0;
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (!ap && rvalid === 1'b1) begin
                d = rdata;
                rs = rresp;
                break;
            end
            if (ap && arready === 1'b1) begin
                ap = 0;
                arvalid <= 1'b0;
            end
            if (n > 50) begin
                chk(1, 0);
                break;
            end
        end
    endtask

    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        chk({rs, d}, {RESP_OKAY, 24'h0, exp});
    endtask

    task automatic pw(input logic [7:0] idx, input logic [7:0] v);
        wr(IDX_KEY, KEY_VALUE);
        chk(rs, RESP_OKAY);
        wr(idx, v);
        chk(rs, RESP_OKAY);
    endtask

    task automatic rst();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (20) @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, arvalid, ext, fsel, flock} = '0;
        {awaddr, araddr, wdata, preq} = '0;
        {bready, rready, wstrb, tick, ardy} = '1;
        @(posedge aclk);
        rst();
        rc(IDX_PRESCALE, PRESC_RESET);
        rc(IDX_FREEZE, 8'h00);
        rc(IDX_STATE, 8'h10);
        rc(IDX_FAST_TRIMA, {2'h0, FREQ_TRIM_0});
        rc(IDX_FAST_TRIMB, {4'h0, TEMP_TRIM_0});
        wr(8'h05, 8'h01);
        chk(rs, RESP_SLVERR);
        rd(8'h05);
        chk({rs, d}, {RESP_SLVERR, 32'h0});
        wr(IDX_PRESCALE, 8'h00);
        rc(IDX_PRESCALE, PRESC_RESET);
        wr(IDX_KEY, KEY_VALUE);
        repeat (4) wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_PRESCALE, 8'h00);
        rc(IDX_PRESCALE, PRESC_RESET);
        wr(IDX_KEY, KEY_VALUE);
        repeat (3) wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_PRESCALE, 8'h01);
        rc(IDX_PRESCALE, 8'h01);
        for (int i = 0; i < 12; i++) begin
            pw(IDX_PRESCALE, {3'h0, code_tab[i], i < 11});
            rc(IDX_PRESCALE, {3'h0, code_tab[i], i < 11});
            repeat (64) @(posedge aclk);
            c = 0;
            repeat (960) @(posedge aclk) c += (pclk === 1'b1);
            chk_n(c, 960 / ratio_tab[i]);
        end
        pw(IDX_PRESCALE, 8'h0d);
        rc(IDX_PRESCALE, 8'h18);
        pw(IDX_SELECT, {6'h0, SRC_RSVD});
        rc(IDX_SELECT, 8'h00);
        chk(pwr[1], 0);
        pw(IDX_SLOW_CTRL, 8'h02);
        repeat (10) @(posedge aclk);
        chk({pwr[1], gate[1]}, 2'b10);
        rc(IDX_STATE, 8'h10);
        preq <= 2'h2;
        ardy <= 2'h1;
        repeat (3) @(posedge aclk);
        chk(gate[1], 0);
        repeat (6) @(posedge aclk);
        chk(gate[1], 1);
        rc(IDX_STATE, 8'h30);
        rd(IDX_IRQ_STAT);
        pw(IDX_SELECT, {6'h0, SRC_EXT});
        rd(IDX_STATE);
        chk(d & 32'h81, 32'h01);
        ext <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(IDX_STATE);
        chk(d & 32'h81, 32'h80);
        rc(IDX_SELECT, 8'h03);
        chk(irq, 0);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge aclk);
        chk(irq, 1);
        rd(IDX_IRQ_STAT);
        chk(d[0], 1);
        repeat (2) @(posedge aclk);
        chk(irq, 0);
        pw(IDX_FAST_TRIMA, 8'h15);
        rc(IDX_FAST_TRIMA, 8'h15);
        pw(IDX_FAST_TRIMB, 8'h03);
        rc(IDX_FAST_TRIMB, 8'h03);
        chk({ttrim, ftrim}, {4'h3, 6'h15});
        pw(IDX_FREEZE, 8'h01);
        pw(IDX_PRESCALE, 8'h03);
        pw(IDX_SELECT, 8'h00);
        rc(IDX_PRESCALE, 8'h18);
        rc(IDX_SELECT, 8'h03);
        pw(IDX_FREEZE, 8'h00);
        pw(IDX_PRESCALE, 8'h03);
        rc(IDX_PRESCALE, 8'h18);
        fsel <= 1'b1;
        flock <= 1'b1;
        rst();
        rc(IDX_FREEZE, 8'h00);
        rc(IDX_FAST_TRIMA, {2'h0, FREQ_TRIM_1});
        rc(IDX_FAST_TRIMB, {4'h8, TEMP_TRIM_1});
        pw(IDX_FAST_TRIMA, 8'h00);
        rc(IDX_FAST_TRIMA, {2'h0, FREQ_TRIM_1});
        pw(IDX_PRESCALE, 8'h01);
        rc(IDX_PRESCALE, 8'h01);
        close_out();
    end
endmodule
